// ---- mdc_mem.sv ----
`timescale 1ns/1ps
module mdc_mem (
	input  wire logic                  core_clk_i,
	input  wire mdc_pkg::mdc_mreq_type req_i,
	input  wire logic [3:0]            dly_i,
	output logic                       ready_o,
	output logic                       err_o,
	output logic [31:0]                rdata_o
);
	logic [31:0] mem [256];
	logic [3:0]  cnt_q = 4'h0;
	initial begin
		ready_o = 1'b0;
		err_o   = 1'b0;
		rdata_o = 32'h5a5a5a5a;
	end
	// Stale data flips each cycle so a late sample never looks valid
	always @(posedge core_clk_i) begin
		ready_o <= 1'b0;
		err_o   <= 1'b0;
		rdata_o <= ~rdata_o;
		if (req_i.req && !ready_o) begin
			if (cnt_q < dly_i) begin
				cnt_q <= cnt_q + 4'h1;
			end else begin
				cnt_q   <= 4'h0;
				ready_o <= 1'b1;
				err_o   <= req_i.addr[31];
				if (req_i.we) begin
					mem[req_i.addr[9:2]] <= req_i.wdata;
				end else begin
					rdata_o <= mem[req_i.addr[9:2]];
				end
			end
		end
	end
endmodule

// ---- mdc_pkg.sv ----
package mdc_pkg;
	localparam int          NCH        = 6;
	localparam int          NTRIG      = 8;
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_BASE   = 12'h004;
	localparam logic [11:0] OFS_SWTRIG = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [11:0] OFS_CH0    = 12'h020;
	localparam logic [11:0] OFS_CHEND  = OFS_CH0 + 12'(NCH * 8);
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_RR    = 8;
	localparam int          FLG_TCMPL  = 0;
	localparam int          FLG_TERR   = 1;
	localparam int          FLG_SUSP   = 2;
	localparam int          FLG_BLK    = 3;
	localparam int          BACT_INT   = 0;
	localparam int          BACT_SUSP  = 1;
	localparam logic [16:0] CNT_MAX    = 17'h10000;
	localparam logic [1:0]  TACT_BEAT  = 2'h0;
	localparam logic [1:0]  TACT_TRANS = 2'h2;
	localparam logic [1:0]  EVA_START  = 2'h0;
	localparam logic [1:0]  EVA_PERIOD = 2'h1;
	localparam logic [1:0]  EVA_COND   = 2'h2;
	localparam logic [1:0]  EVA_SUSP   = 2'h3;
	localparam logic [1:0]  EVO_BEAT   = 2'h1;
	localparam logic [1:0]  EVO_BLOCK  = 2'h2;
	localparam logic [1:0]  EVO_TRANS  = 2'h3;
	localparam logic [1:0]  SIZE_WORD  = 2'h2;

	typedef enum logic [1:0] {S_IDLE, S_DESC, S_READ, S_WRITE} mdc_fsm_type;

	typedef struct packed {
		logic [3:0] inten;
		logic [2:0] tsrc;
		logic       ptrig;
		logic       evie;
		logic [1:0] evact;
		logic [1:0] lvl;
		logic [1:0] tact;
		logic       susp;
		logic       en;
	} mdc_chctrl_type;

	typedef struct packed {
		logic [7:0] rsv;
		logic       dinc;
		logic       sinc;
		logic [1:0] bsize;
		logic [1:0] bact;
		logic [1:0] evosel;
	} mdc_btctrl_type;

	typedef struct packed {
		logic           valid;
		logic [16:0]    cnt;
		mdc_btctrl_type ctl;
		logic [31:0]    src;
		logic [31:0]    dst;
		logic [31:0]    next;
	} mdc_wb_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mdc_mreq_type;

	typedef struct packed {
		mdc_fsm_type                fsm;
		logic [2:0]                 ach;
		logic [1:0]                 widx;
		logic                       stop;
		logic                       en;
		logic [3:0]                 rr;
		logic [31:0]                base;
		logic [31:0]                dptr;
		mdc_chctrl_type [NCH-1:0]   cc;
		logic [NCH-1:0][3:0]        flg;
		logic [NCH-1:0]             pend;
		logic [NCH-1:0]             evp;
		logic [NCH-1:0]             evo;
		logic [3:0][2:0]            last;
		mdc_wb_type [NCH-1:0]       wb;
		mdc_wb_type                 cur;
		logic [31:0]                prdata;
		logic                       perr;
		logic                       irq;
		mdc_mreq_type               mreq;
	} mdc_state_type;
endpackage

// ---- mdc_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Each beat reads source, then writes destination; next read waits for write.
// - Software, peripheral or event input can trigger a channel.
// - Block count spans 1 to 64K beats; zero in descriptor means 64K.
// - Beat size is byte, half-word or word for both sides.
// - Six channels, each with independent state.
// - Each channel fetches a four-word descriptor from memory.
// - Source and destination each stay fixed or advance per beat.
// - Per-channel control selects trigger mode, source, event action, priority.
// - Each channel keeps its progress in its own write-back area.
// - Four priority levels, each fixed-order or round-robin.
// - Nonzero next pointer chains descriptors on the same channel.
// - Transfer starts only with controller and channel enabled and trigger pending.
// - Trigger moves one beat, one block or a whole transaction.
// - Channel enable clears itself after the last descriptor's block.
// - Software suspends or resumes any time; block end may suspend.
// - Interrupt on transaction end, selected block, bus error, suspension.
// - Each channel has exactly one event input.
// - Event action: start, periodic, conditional gate, or suspend/resume toggle.
// - Event output pulses on beat, block or transaction end.
module mdc_top #(
	parameter int NTRIG = mdc_pkg::NTRIG
) (
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [11:0]                paddr_i,
	input  wire logic [31:0]                pwdata_i,
	output logic      [31:0]                prdata_o,
	output logic                            pready_o,
	output logic                            pslverr_o,
	output mdc_pkg::mdc_mreq_type           mem_o,
	input  wire logic                       mem_ready_i,
	input  wire logic                       mem_err_i,
	input  wire logic [31:0]                mem_rdata_i,
	input  wire logic [NTRIG-1:0]           ptrig_i,
	input  wire logic [mdc_pkg::NCH-1:0]    ev_i,
	output logic      [mdc_pkg::NCH-1:0]    ev_o,
	output logic                            irq_o
);
	localparam int NCH = mdc_pkg::NCH;

	mdc_pkg::mdc_state_type q;
	mdc_pkg::mdc_state_type n;
	logic [1:0]             rsync_q;
	logic                   rst_n;

	function automatic logic [2:0] chsel(input logic [11:0] a);
		logic [11:0] d;
		d = (a - mdc_pkg::OFS_CH0) >> 3;
		return d[2:0];
	endfunction

	function automatic logic [32:0] reg_read(
		input mdc_pkg::mdc_state_type s,
		input logic [11:0]            a
	);
		logic [2:0] c;
		c = chsel(a);
		if (a[1:0] != 2'h0)
			return {1'b1, 32'h0};
		if (a == mdc_pkg::OFS_CTRL)
			return {1'b0, 20'h0, s.rr, 7'h0, s.en};
		if (a == mdc_pkg::OFS_BASE)
			return {1'b0, s.base};
		if (a == mdc_pkg::OFS_SWTRIG)
			return {1'b0, 26'h0, s.pend};
		if (a == mdc_pkg::OFS_STATUS)
			return {1'b0, 25'h0, s.ach, 3'h0, s.fsm != mdc_pkg::S_IDLE};
		if (a >= mdc_pkg::OFS_CH0 && a < mdc_pkg::OFS_CHEND) begin
			if (a[2])
				return {1'b0, s.wb[c].cnt, 6'h0, s.wb[c].valid, 4'h0, s.flg[c]};
			return {1'b0, 15'h0, s.cc[c]};
		end
		return {1'b1, 32'h0};
	endfunction

	// Highest level wins; later levels overwrite lower ones
	function automatic logic [3:0] pick(
		input logic [NCH-1:0]                   el,
		input mdc_pkg::mdc_chctrl_type [NCH-1:0] cc,
		input logic [3:0]                       rr,
		input logic [3:0][2:0]                  last
	);
		logic [3:0] r;
		logic       hit;
		int         j;
		r = 4'h0;
		for (int l = 0; l < 4; l++) begin
			hit = 1'b0;
			for (int k = 0; k < NCH; k++) begin
				j = rr[l] ? (int'(last[l]) + 1 + k) % NCH : k;
				if (!hit && el[j] && cc[j].lvl == 2'(l)) begin
					hit = 1'b1;
					r = {1'b1, 3'(j)};
				end
			end
		end
		return r;
	endfunction

	function automatic mdc_pkg::mdc_mreq_type rd_req(
		input logic [31:0] ad,
		input logic [1:0]  sz
	);
		mdc_pkg::mdc_mreq_type m;
		m = '0;
		m.req = 1'b1;
		m.size = sz;
		m.addr = ad;
		return m;
	endfunction

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rsync_q <= 2'h0;
		else
			rsync_q <= {rsync_q[0], 1'b1};
	end
	assign rst_n = rsync_q[1];

	always_comb begin
		logic [3:0]     pk;
		logic [2:0]     a;
		logic [2:0]     c;
		logic [31:0]    step;
		logic [7:0]     ptv;
		logic           wr;
		logic           evr;
		logic           gate;
		logic           done;
		logic [NCH-1:0] ok;
		mdc_pkg::mdc_btctrl_type ctl;
		mdc_pkg::mdc_wb_type     w;
		pk = 4'h0;
		evr = 1'b0;
		gate = 1'b0;
		ok = '0;
		done = mem_ready_i && !mem_err_i;
		w = q.cur;
		n = q;
		n.evo = '0;
		a = q.ach;
		c = chsel(paddr_i);
		wr = psel_i && penable_i && pwrite_i && !q.perr;
		ptv = 8'(ptrig_i);
		ctl = q.cur.ctl;
		step = 32'h1 << ctl.bsize;
		if (psel_i && !penable_i)
			{n.perr, n.prdata} = reg_read(q, paddr_i);
		if (wr) begin
			if (paddr_i == mdc_pkg::OFS_CTRL) begin
				n.en = pwdata_i[mdc_pkg::CTRL_EN];
				n.rr = pwdata_i[mdc_pkg::CTRL_RR +: 4];
			end else if (paddr_i == mdc_pkg::OFS_BASE) begin
				n.base = {pwdata_i[31:4], 4'h0};
			end else if (paddr_i[11:5] != 7'h0 && paddr_i[2]) begin
				n.flg[c] = q.flg[c] & ~pwdata_i[3:0];
			end else if (paddr_i[11:5] != 7'h0) begin
				n.cc[c] = pwdata_i[16:0];
				if (pwdata_i[1] && !q.cc[c].susp)
					n.flg[c][mdc_pkg::FLG_SUSP] = 1'b1;
			end
		end
		for (int i = 0; i < NCH; i++) begin
			evr = ev_i[i] && !q.evp[i];
			n.evp[i] = ev_i[i];
			gate = !(q.cc[i].evie && q.cc[i].evact == mdc_pkg::EVA_COND)
				|| ev_i[i];
			if (gate && ((q.cc[i].ptrig && ptv[q.cc[i].tsrc])
				|| (wr && paddr_i == mdc_pkg::OFS_SWTRIG && pwdata_i[i])
				|| (q.cc[i].evie && evr
				&& (q.cc[i].evact == mdc_pkg::EVA_START
				|| q.cc[i].evact == mdc_pkg::EVA_PERIOD))))
				n.pend[i] = 1'b1;
			if (q.cc[i].evie && evr && q.cc[i].evact == mdc_pkg::EVA_SUSP) begin
				n.cc[i].susp = !n.cc[i].susp;
				if (n.cc[i].susp)
					n.flg[i][mdc_pkg::FLG_SUSP] = 1'b1;
			end
			if (!n.cc[i].en) begin
				n.pend[i] = 1'b0;
				if (q.fsm == mdc_pkg::S_IDLE || q.ach != 3'(i))
					n.wb[i] = '0;
			end
		end
		// All six channels; suspended ones never reach the arbiter
		for (int i = 0; i < NCH; i++) begin
			ok[i] = q.en && q.cc[i].en && !q.cc[i].susp;
		end
		pk = pick(q.pend & ok, q.cc, q.rr, q.last);
		case (q.fsm)
			mdc_pkg::S_IDLE: begin
				n.mreq = '0;
				if (pk[3]) begin
					a = pk[2:0];
					n.ach = a;
					n.pend[a] = 1'b0;
					n.last[q.cc[a].lvl] = a;
					if (q.wb[a].valid) begin
						n.cur = q.wb[a];
						n.fsm = mdc_pkg::S_READ;
						n.mreq = rd_req(q.wb[a].src, q.wb[a].ctl.bsize);
					end else begin
						n.dptr = (q.wb[a].next != 32'h0) ? q.wb[a].next
							: q.base + {25'h0, a, 4'h0};
						n.widx = 2'h0;
						n.fsm = mdc_pkg::S_DESC;
						n.mreq = rd_req(n.dptr, mdc_pkg::SIZE_WORD);
					end
				end
			end
			mdc_pkg::S_DESC: begin
				if (done) begin
					n.widx = q.widx + 2'h1;
					n.mreq.addr = q.mreq.addr + 32'h4;
					case (q.widx)
						2'h0: begin
							n.cur.cnt = (mem_rdata_i[31:16] == 16'h0)
								? mdc_pkg::CNT_MAX
								: {1'b0, mem_rdata_i[31:16]};
							n.cur.ctl = mem_rdata_i[15:0];
						end
						2'h1: n.cur.src = mem_rdata_i;
						2'h2: n.cur.dst = mem_rdata_i;
						default: begin
							n.cur.next = mem_rdata_i;
							n.cur.valid = 1'b1;
							n.fsm = mdc_pkg::S_READ;
							n.mreq = rd_req(q.cur.src, q.cur.ctl.bsize);
						end
					endcase
				end
			end
			mdc_pkg::S_READ: begin
				if (done) begin
					n.fsm = mdc_pkg::S_WRITE;
					n.mreq.we = 1'b1;
					n.mreq.addr = q.cur.dst;
					n.mreq.wdata = mem_rdata_i;
				end
			end
			mdc_pkg::S_WRITE: begin
				if (done) begin
					w.src = q.cur.src + (ctl.sinc ? step : 32'h0);
					w.dst = q.cur.dst + (ctl.dinc ? step : 32'h0);
					w.cnt = q.cur.cnt - 17'h1;
					n.mreq = '0;
					n.fsm = mdc_pkg::S_IDLE;
					n.evo[a] = ctl.evosel == mdc_pkg::EVO_BEAT;
					if (w.cnt == 17'h0) begin
						w.valid = 1'b0;
						if (ctl.evosel == mdc_pkg::EVO_BLOCK)
							n.evo[a] = 1'b1;
						if (ctl.bact == mdc_pkg::BACT_INT)
							n.flg[a][mdc_pkg::FLG_BLK] = 1'b1;
						if (ctl.bact == mdc_pkg::BACT_SUSP) begin
							n.cc[a].susp = 1'b1;
							n.flg[a][mdc_pkg::FLG_SUSP] = 1'b1;
						end
					end
					n.cur = w;
					n.wb[a] = w;
					if (w.cnt == 17'h0 && q.cur.next == 32'h0) begin
						n.cc[a].en = 1'b0;
						n.flg[a][mdc_pkg::FLG_TCMPL] = 1'b1;
						if (ctl.evosel == mdc_pkg::EVO_TRANS)
							n.evo[a] = 1'b1;
						n.wb[a] = '0;
					end else if (n.cc[a].susp
						|| q.cc[a].tact == mdc_pkg::TACT_BEAT
						|| (w.cnt == 17'h0
						&& q.cc[a].tact != mdc_pkg::TACT_TRANS)) begin
						// Progress parked in write-back until next trigger
						n.fsm = mdc_pkg::S_IDLE;
					end else if (w.cnt == 17'h0) begin
						n.dptr = q.cur.next;
						n.widx = 2'h0;
						n.fsm = mdc_pkg::S_DESC;
						n.mreq = rd_req(q.cur.next, mdc_pkg::SIZE_WORD);
					end else begin
						n.fsm = mdc_pkg::S_READ;
						n.mreq = rd_req(w.src, ctl.bsize);
					end
				end
			end
			default: begin
				n.fsm = mdc_pkg::S_IDLE;
			end
		endcase
		// Error after the clear decode so the flag set wins
		if (q.fsm != mdc_pkg::S_IDLE && mem_ready_i && mem_err_i) begin
			n.fsm = mdc_pkg::S_IDLE;
			n.mreq = '0;
			n.cc[q.ach].en = 1'b0;
			n.flg[q.ach][mdc_pkg::FLG_TERR] = 1'b1;
			n.wb[q.ach] = '0;
			n.cur = '0;
		end
		n.irq = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			n.irq = n.irq || (|(n.flg[i] & n.cc[i].inten));
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end

	assign prdata_o  = q.prdata;
	assign pready_o  = psel_i && penable_i;
	assign pslverr_o = psel_i && penable_i && q.perr;
	assign mem_o     = q.mreq;
	assign ev_o      = q.evo;
	assign irq_o     = q.irq;

	sequence s_rd_done;
		q.fsm == mdc_pkg::S_READ && mem_ready_i && !mem_err_i;
	endsequence
	sequence s_last_beat;
		q.fsm == mdc_pkg::S_WRITE && mem_ready_i && !mem_err_i
			&& q.cur.cnt == 17'h1 && q.cur.next == 32'h0;
	endsequence
	sequence s_bus_err;
		q.fsm != mdc_pkg::S_IDLE && mem_ready_i && mem_err_i;
	endsequence
	property p_rd_then_wr;
		@(posedge core_clk_i) disable iff (!rst_n)
		s_rd_done |=> q.fsm == mdc_pkg::S_WRITE && q.mreq.we;
	endproperty
	a_rd_then_wr: assert property (p_rd_then_wr)
		else $error("write did not follow read");
	property p_req_hold;
		@(posedge core_clk_i) disable iff (!rst_n)
		q.mreq.req && !mem_ready_i |=> $stable(q.mreq);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("bus request changed before ready");
	property p_grant;
		@(posedge core_clk_i) disable iff (!rst_n)
		q.fsm == mdc_pkg::S_IDLE && n.fsm != mdc_pkg::S_IDLE
			|-> q.en && q.cc[n.ach].en && q.pend[n.ach];
	endproperty
	a_grant: assert property (p_grant)
		else $error("transfer started without enable or trigger");
	property p_cnt;
		@(posedge core_clk_i) disable iff (!rst_n)
		(q.fsm == mdc_pkg::S_READ || q.fsm == mdc_pkg::S_WRITE)
			|-> q.cur.cnt != 17'h0;
	endproperty
	a_cnt: assert property (p_cnt)
		else $error("beat moved with zero count");
	property p_done;
		@(posedge core_clk_i) disable iff (!rst_n)
		s_last_beat |=> !q.cc[q.ach].en
			&& q.flg[q.ach][mdc_pkg::FLG_TCMPL];
	endproperty
	a_done: assert property (p_done)
		else $error("channel still enabled after last block");
	property p_err;
		@(posedge core_clk_i) disable iff (!rst_n)
		s_bus_err |=> q.fsm == mdc_pkg::S_IDLE && !q.mreq.req
			&& q.flg[q.ach][mdc_pkg::FLG_TERR] && !q.cc[q.ach].en;
	endproperty
	a_err: assert property (p_err)
		else $error("bus error did not stop the channel");
endmodule

// ---- multichannel_dma_controller_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module multichannel_dma_controller_bench;
	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    psel = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite = 1'b0;
	logic [11:0]             paddr = 12'h000;
	logic [31:0]             pwdata = 32'h0;
	logic [31:0]             prdata, r;
	logic                    pready, pslverr, mrdy, merr, irq, re;
	logic [5:0]              evo;
	int                      n_ev = 0;
	logic [31:0]             mrd;
	logic [3:0]              dly = 4'h2;
	mdc_pkg::mdc_mreq_type   mreq;
	mdc_pkg::mdc_chctrl_type cc;
	mdc_pkg::mdc_btctrl_type bc;
	int                      errors = 0;
	int                      n_checks = 0;
	always #5 clk = ~clk;
	mdc_top DUT (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .mem_o(mreq), .mem_ready_i(mrdy),
		.mem_err_i(merr), .mem_rdata_i(mrd), .ptrig_i(8'h00),
		.ev_i(6'h00), .ev_o(evo), .irq_o(irq));
	always @(posedge clk) if (evo[0]) n_ev++;
	mdc_mem M (.core_clk_i(clk), .req_i(mreq), .dly_i(dly),
		.ready_o(mrdy), .err_o(merr), .rdata_o(mrd));
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			errors++;
			tally_and_finish();
		end
		r = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Software trigger on one channel, then poll until enable drops
	task automatic run_ch(input int ch, input logic [31:0] src,
		input logic [3:0] exp);
		int k;
		k = 0;
		M.mem[64 + ch * 4] = {16'h0004, 16'(bc)};
		M.mem[65 + ch * 4] = src;
		M.mem[66 + ch * 4] = 32'h280;
		M.mem[67 + ch * 4] = 32'h0;
		apb(1'b1, mdc_pkg::OFS_CH0 + 12'(ch * 8), 32'(cc));
		apb(1'b1, mdc_pkg::OFS_SWTRIG, 32'h1 << ch);
		r = 32'h1;
		while (r[0] !== 1'b0 && k < 200) begin
			apb(1'b0, mdc_pkg::OFS_CH0 + 12'(ch * 8), 32'h0);
			k++;
		end
		`CHK(r[0], 1'b0)
		`CHK(irq, 1'b1)
		apb(1'b0, mdc_pkg::OFS_CH0 + 12'(ch * 8 + 4), 32'h0);
		`CHK(r[3:0], exp)
		apb(1'b1, mdc_pkg::OFS_CH0 + 12'(ch * 8 + 4), 32'hf);
		`CHK(irq, 1'b0)
	endtask
	task automatic t_copy();
		for (int i = 0; i < 4; i++) begin
			M.mem[128 + i] = 32'h1000 + i;
		end
		run_ch(0, 32'h200, 4'h9);
		`CHK(n_ev, 4)
		apb(1'b0, 12'h010, 32'h0);
		`CHK(re, 1'b1)
		for (int i = 0; i < 4; i++) begin
			`CHK(M.mem[160 + i], 32'h1000 + i)
		end
		$display("copy done");
	endtask
	// High address bit makes the memory model answer with an error
	task automatic t_err();
		M.mem[160] = 32'hdead0000;
		run_ch(1, 32'h80000200, 4'h2);
		`CHK(M.mem[160], 32'hdead0000)
		$display("bus error done");
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		cc = '0;
		cc.en = 1'b1;
		cc.tact = mdc_pkg::TACT_TRANS;
		cc.inten = 4'hf;
		bc = '0;
		bc.bsize = mdc_pkg::SIZE_WORD;
		bc.sinc = 1'b1;
		bc.dinc = 1'b1;
		bc.evosel = mdc_pkg::EVO_BEAT;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b1, mdc_pkg::OFS_BASE, 32'h100);
		apb(1'b1, mdc_pkg::OFS_CTRL, 32'h1 << mdc_pkg::CTRL_EN);
		t_copy();
		t_err();
		tally_and_finish();
	end
endmodule
